/* hbuf_host_model.sv */
// Host link and buffer manager model: received bytes, locks and manager events
`timescale 1ns/1ps
`default_nettype none
module hbuf_host_model (
    input wire logic clk_i,
    output var hbuf_pkg::rx_byte_s rx_byte_o,
    output var hbuf_pkg::mgr_evt_s evt_o
);
    import hbuf_pkg::*;
    initial begin
        rx_byte_o = '0;
        evt_o = '0;
    end
    // Between bytes the data lines show the inverse of the last byte
    task automatic send_frame(input logic [1:0] idx, input int n, input int gap,
                              input logic chk, input logic ok, input logic close);
        for (int i = 1; i <= n; i++) begin
            @(posedge clk_i);
            rx_byte_o <= '{1'b1, idx, 8'(i), chk && close && i == n, ok, close && i == n, 1'b1};
            @(posedge clk_i);
            rx_byte_o <= '{1'b0, idx, ~8'(i), 1'b0, 1'b0, 1'b0, 1'b0};
            repeat (gap) @(posedge clk_i);
        end
    endtask : send_frame
    task automatic set_lock(input logic [NBUF-1:0] l);
        @(posedge clk_i);
        evt_o.lock <= l;
    endtask : set_lock
    task automatic mgr_pulse(input logic [NRX-1:0] ok, input logic sent);
        @(posedge clk_i);
        evt_o.rx_frame_ok <= ok;
        evt_o.tx_sent <= sent;
        @(posedge clk_i);
        evt_o.rx_frame_ok <= '0;
        evt_o.tx_sent <= 1'b0;
        @(posedge clk_i);
    endtask : mgr_pulse
endmodule : hbuf_host_model
`default_nettype wire

/* hbuf_pkg.sv */
// Package: register map, field layout and timing constants of the buffer length/ready block
package hbuf_pkg;

    // ==================================================================
    // Register byte offsets
    localparam logic [7:0] OFF_RX0_LEN = 8'h4c;
    localparam logic [7:0] OFF_RX1_LEN = 8'h50;
    localparam logic [7:0] OFF_RX2_LEN = 8'h54;
    localparam logic [7:0] OFF_RX3_LEN = 8'h58;
    localparam logic [7:0] OFF_TX_LEN = 8'h5c;
    localparam logic [7:0] OFF_TIMEOUT = 8'h60;
    localparam logic [7:0] OFF_THRESH = 8'h64;
    localparam logic [7:0] OFF_SET = 8'h68;
    localparam logic [7:0] OFF_CLR = 8'h6c;
    localparam logic [7:0] OFF_READY = 8'h70;
    localparam logic [7:0] OFF_CTRL = 8'h80;
    localparam logic [7:0] OFF_IRQ_STAT = 8'h84;
    localparam logic [7:0] OFF_IRQ_MASK = 8'h88;

    // ==================================================================
    // Field layout
    localparam int LEN_W = 11;
    localparam int TMO_W = 16;
    localparam int NRX = 4;
    localparam int NBUF = 5;
    localparam int POS_MATCH = 12;
    localparam int POS_SEEN = 11;
    localparam int POS_TX = 4;
    localparam int NIRQ = 3;
    localparam int IRQ_TIMEOUT = 0;
    localparam int IRQ_THRESH = 1;
    localparam int IRQ_RXDONE = 2;

    // ==================================================================
    // Reset values
    localparam logic [LEN_W-1:0] RST_LEN = 11'h000;
    localparam logic [TMO_W-1:0] RST_TMO = 16'h0000;
    localparam logic [NBUF-1:0] RST_READY = 5'h00;
    localparam logic [NIRQ-1:0] RST_IRQ = 3'h0;

    // ==================================================================
    // Timing: one timeout step is 3.6 us, clock period 40 ns
    localparam int CLK_PERIOD_PS = 40000;
    localparam int TMO_STEP_PS = 3600;
    localparam int TMO_STEP_NS_X10 = 36;
    localparam int STEP_CYC_INT = (TMO_STEP_PS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam logic [7:0] STEP_CYCLES = 8'(STEP_CYC_INT);

    // ==================================================================
    // Carriers
    typedef struct packed {
        logic valid;
        logic [1:0] buf_idx;
        logic [7:0] data;
        logic is_check;
        logic check_ok;
        logic last;
        logic good;
    } rx_byte_s;

    typedef struct packed {
        logic [NBUF-1:0] lock;
        logic [NRX-1:0] rx_frame_ok;
        logic tx_sent;
    } mgr_evt_s;

endpackage : hbuf_pkg

/* hbuf_regs.sv */
// APB register bank: receive lengths, transmit length, timeout, threshold, ready flags
// Functional notes
// - Each receive buffer reports at bit 12 whether its final byte matched the computed check code.
// - Each receive buffer reports at bit 11 whether its final byte was recognised as a check code.
// - Each receive buffer has a read-only 11-bit byte count in bits 10:0, valid in length-field mode.
// - The transmit length is a read-write 11-bit field in bits 10:0, used in length-field mode.
// - A 16-bit inter-character timeout counts 3.6 us steps, and zero switches it off.
// - An interrupt fires when a frame's byte count reaches the 11-bit threshold, zero disabling it.
// - A write-only set register sets the transmit ready flag at bit 4 and receive flags at 3..0.
// - A set request is ignored while the buffer manager holds that buffer's lock.
// - A write-only clear register clears the transmit ready flag at bit 4 and receive flags at 3..0.
// - Clearing the transmit ready flag works only while the transmit lock is free.
// - The manager sets a receive flag on a good frame and clears the transmit flag when sent.
// - Clearing a receive ready flag works only while that receive buffer's lock is free.
//
// Our own choice: register access over APB.
`timescale 1ns/1ps
`default_nettype none
module hbuf_regs (
    input wire logic REF_CLK_I,
    input wire logic RST_N_I,
    input wire logic CE_I,
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [7:0] PADDR_I,
    input wire logic [31:0] PWDATA_I,
    output logic [31:0] PRDATA_O,
    output logic PREADY_O,
    output logic PSLVERR_O,
    input wire hbuf_pkg::rx_byte_s RX_BYTE_I,
    input wire hbuf_pkg::mgr_evt_s MGR_EVT_I,
    output logic [hbuf_pkg::NBUF-1:0] READY_FLAGS_O,
    output logic [hbuf_pkg::LEN_W-1:0] TX_LENGTH_O,
    output logic LENGTH_FIELD_MODE_O,
    output logic RX_TIMEOUT_O,
    output logic IRQ_O
);
    import hbuf_pkg::*;

    // ==================================================================
    // State
    typedef struct packed {
        logic [NRX-1:0][LEN_W-1:0] rx_count;
        logic [NRX-1:0] rx_match;
        logic [NRX-1:0] rx_seen;
        logic [LEN_W-1:0] live_count;
        logic thresh_done;
        logic [LEN_W-1:0] tx_len;
        logic [TMO_W-1:0] tmo;
        logic [LEN_W-1:0] thresh;
        logic [NBUF-1:0] ready;
        logic mode;
        logic [NIRQ-1:0] irq_stat;
        logic [NIRQ-1:0] irq_mask;
        logic [31:0] rdata;
    } regs_state_s;

    regs_state_s state_ff;
    regs_state_s nxt_state;
    logic wr_en;
    logic rd_en;
    logic hit;
    logic tmo_evt;
    logic [NIRQ-1:0] irq_evt;
    logic [NBUF-1:0] set_req;
    logic [NBUF-1:0] clr_req;

    // Decode of the offsets this bank answers
    function automatic logic addr_known(input logic [7:0] a);
        logic ok;
        ok = 1'b0;
        case (a)
            OFF_RX0_LEN, OFF_RX1_LEN, OFF_RX2_LEN, OFF_RX3_LEN, OFF_TX_LEN,
            OFF_TIMEOUT, OFF_THRESH, OFF_SET, OFF_CLR, OFF_READY,
            OFF_CTRL, OFF_IRQ_STAT, OFF_IRQ_MASK: ok = 1'b1;
            default: ok = 1'b0;
        endcase
        return ok;
    endfunction : addr_known

    function automatic logic [31:0] len_word(input logic m, input logic s,
                                             input logic [LEN_W-1:0] c);
        logic [31:0] w;
        w = 32'h0000_0000;
        w[POS_MATCH] = m;
        w[POS_SEEN] = s;
        w[LEN_W-1:0] = c;
        return w;
    endfunction : len_word

    // ==================================================================
    // Bus decode: zero-wait slave, unmapped offsets flag an error
    assign hit = PSEL_I && PENABLE_I;
    assign wr_en = hit && PWRITE_I && addr_known(PADDR_I);
    assign rd_en = PSEL_I && !PENABLE_I && !PWRITE_I;
    assign PREADY_O = 1'b1;
    assign PSLVERR_O = hit && !addr_known(PADDR_I);
    assign PRDATA_O = state_ff.rdata;

    hbuf_timeout u_timeout (
        .clk_i(REF_CLK_I),
        .rst_n_i(RST_N_I),
        .ce_i(CE_I),
        .limit_i(state_ff.tmo),
        .byte_i(RX_BYTE_I.valid),
        .frame_end_i(RX_BYTE_I.last),
        .expire_o(tmo_evt)
    );

    assign set_req = (wr_en && PADDR_I == OFF_SET) ? PWDATA_I[NBUF-1:0] : '0;
    assign clr_req = (wr_en && PADDR_I == OFF_CLR) ? PWDATA_I[NBUF-1:0] : '0;

    // ==================================================================
    // Next state
    always_comb begin
        nxt_state = state_ff;
        irq_evt = '0;
        irq_evt[IRQ_TIMEOUT] = tmo_evt;

        // Per-byte capture of the live frame count
        if (RX_BYTE_I.valid) begin
            nxt_state.live_count = state_ff.live_count + 11'h001;
            if (!state_ff.thresh_done && state_ff.thresh != RST_LEN
                && state_ff.live_count + 11'h001 == state_ff.thresh) begin
                irq_evt[IRQ_THRESH] = 1'b1;
                nxt_state.thresh_done = 1'b1;
            end
            if (RX_BYTE_I.last) begin
                nxt_state.rx_count[RX_BYTE_I.buf_idx] = state_ff.live_count + 11'h001;
                nxt_state.rx_seen[RX_BYTE_I.buf_idx] = RX_BYTE_I.is_check;
                nxt_state.rx_match[RX_BYTE_I.buf_idx] =
                    RX_BYTE_I.is_check && RX_BYTE_I.check_ok;
                nxt_state.live_count = RST_LEN;
                nxt_state.thresh_done = 1'b0;
                irq_evt[IRQ_RXDONE] = RX_BYTE_I.good;
            end
        end

        // Firmware register writes
        if (wr_en) begin
            case (PADDR_I)
                OFF_TX_LEN: nxt_state.tx_len = PWDATA_I[LEN_W-1:0];
                OFF_TIMEOUT: nxt_state.tmo = PWDATA_I[TMO_W-1:0];
                OFF_THRESH: nxt_state.thresh = PWDATA_I[LEN_W-1:0];
                OFF_CTRL: nxt_state.mode = PWDATA_I[0];
                OFF_IRQ_MASK: nxt_state.irq_mask = PWDATA_I[NIRQ-1:0];
                default: nxt_state.tx_len = state_ff.tx_len;
            endcase
        end

        // Ready flags: firmware gated by locks, manager events win last
        for (int i = 0; i < NBUF; i++) begin
            if (clr_req[i] && !MGR_EVT_I.lock[i]) begin
                nxt_state.ready[i] = 1'b0;
            end
            if (set_req[i] && !MGR_EVT_I.lock[i]) begin
                nxt_state.ready[i] = 1'b1;
            end
        end
        for (int i = 0; i < NRX; i++) begin
            if (MGR_EVT_I.rx_frame_ok[i]) begin
                nxt_state.ready[i] = 1'b1;
            end
        end
        if (MGR_EVT_I.tx_sent) begin
            nxt_state.ready[POS_TX] = 1'b0;
        end

        // Sticky status: a new event beats a simultaneous clear
        if (wr_en && PADDR_I == OFF_IRQ_STAT) begin
            nxt_state.irq_stat = state_ff.irq_stat & ~PWDATA_I[NIRQ-1:0];
        end
        nxt_state.irq_stat = nxt_state.irq_stat | irq_evt;

        // Read data latched in the setup cycle, stable through access
        if (rd_en) begin
            case (PADDR_I)
                OFF_RX0_LEN: nxt_state.rdata = len_word(state_ff.rx_match[0],
                    state_ff.rx_seen[0], state_ff.rx_count[0]);
                OFF_RX1_LEN: nxt_state.rdata = len_word(state_ff.rx_match[1],
                    state_ff.rx_seen[1], state_ff.rx_count[1]);
                OFF_RX2_LEN: nxt_state.rdata = len_word(state_ff.rx_match[2],
                    state_ff.rx_seen[2], state_ff.rx_count[2]);
                OFF_RX3_LEN: nxt_state.rdata = len_word(state_ff.rx_match[3],
                    state_ff.rx_seen[3], state_ff.rx_count[3]);
                OFF_TX_LEN: nxt_state.rdata = {21'h00_0000, state_ff.tx_len};
                OFF_TIMEOUT: nxt_state.rdata = {16'h0000, state_ff.tmo};
                OFF_THRESH: nxt_state.rdata = {21'h00_0000, state_ff.thresh};
                OFF_READY: nxt_state.rdata = {27'h000_0000, state_ff.ready};
                OFF_CTRL: nxt_state.rdata = {31'h0000_0000, state_ff.mode};
                OFF_IRQ_STAT: nxt_state.rdata = {29'h0000_0000, state_ff.irq_stat};
                OFF_IRQ_MASK: nxt_state.rdata = {29'h0000_0000, state_ff.irq_mask};
                default: nxt_state.rdata = 32'h0000_0000;
            endcase
        end
    end

    // ==================================================================
    // Registers
    always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            state_ff <= '0;
        end else if (CE_I) begin
            state_ff <= nxt_state;
        end
    end

    assign READY_FLAGS_O = state_ff.ready;
    assign TX_LENGTH_O = state_ff.tx_len;
    assign LENGTH_FIELD_MODE_O = state_ff.mode;
    assign RX_TIMEOUT_O = state_ff.irq_stat[IRQ_TIMEOUT];
    assign IRQ_O = |(state_ff.irq_stat & state_ff.irq_mask);
endmodule : hbuf_regs
`default_nettype wire

/* hbuf_regs_assertions.sv */
// Concurrent checks on the ready-flag, length and bus-error behaviour of the register bank
`timescale 1ns/1ps
`default_nettype none
module hbuf_regs_checker
    import hbuf_pkg::*;
(
    input wire logic REF_CLK_I,
    input wire logic RST_N_I,
    input wire logic CE_I,
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [7:0] PADDR_I,
    input wire logic [31:0] PWDATA_I,
    input wire logic PSLVERR_O,
    input wire hbuf_pkg::mgr_evt_s MGR_EVT_I,
    input wire logic [hbuf_pkg::NBUF-1:0] READY_FLAGS_O,
    input wire logic [hbuf_pkg::LEN_W-1:0] TX_LENGTH_O
);
    // ==================================================================
    // Helper terms
    logic wr, wr_set, wr_clr, mapped;
    logic [NBUF-1:0] lk, mset, mclr, set_ok, set_no, clr_ok, clr_no;
    assign wr = PSEL_I && PENABLE_I && PWRITE_I && CE_I;
    assign wr_set = wr && PADDR_I == OFF_SET;
    assign wr_clr = wr && PADDR_I == OFF_CLR;
    assign mapped = PADDR_I inside {OFF_RX0_LEN, OFF_RX1_LEN, OFF_RX2_LEN, OFF_RX3_LEN,
        OFF_TX_LEN, OFF_TIMEOUT, OFF_THRESH, OFF_SET, OFF_CLR, OFF_READY, OFF_CTRL,
        OFF_IRQ_STAT, OFF_IRQ_MASK};
    assign lk = MGR_EVT_I.lock;
    assign mset = {1'b0, MGR_EVT_I.rx_frame_ok};
    assign mclr = {MGR_EVT_I.tx_sent, 4'h0};
    // Manager events win over firmware, so those bits are left out
    assign set_ok = wr_set ? PWDATA_I[4:0] & ~lk & ~mclr : '0;
    assign set_no = wr_set ? PWDATA_I[4:0] & lk & ~mset & ~READY_FLAGS_O : '0;
    assign clr_ok = wr_clr ? PWDATA_I[4:0] & ~lk & ~mset : '0;
    assign clr_no = wr_clr ? PWDATA_I[4:0] & lk & ~mclr & READY_FLAGS_O : '0;
    default clocking @(posedge REF_CLK_I); endclocking
    default disable iff (!RST_N_I);
    // ==================================================================
    // Assertions
    a_set_takes: assert property (|set_ok
        |=> (READY_FLAGS_O & $past(set_ok)) == $past(set_ok))
        else $error("ready flag not set by firmware");
    a_set_locked: assert property (|set_no |=> (READY_FLAGS_O & $past(set_no)) == '0)
        else $error("ready flag set while locked");
    a_clr_takes: assert property (|clr_ok |=> (READY_FLAGS_O & $past(clr_ok)) == '0)
        else $error("ready flag not cleared by firmware");
    a_clr_locked: assert property (|clr_no
        |=> (READY_FLAGS_O & $past(clr_no)) == $past(clr_no))
        else $error("ready flag cleared while locked");
    a_mgr_sets: assert property (CE_I && |mset
        |=> (READY_FLAGS_O & $past(mset)) == $past(mset))
        else $error("manager frame event did not set flag");
    a_mgr_tx_clear: assert property (CE_I && MGR_EVT_I.tx_sent |=> !READY_FLAGS_O[POS_TX])
        else $error("sent event did not clear transmit flag");
    a_flags_hold: assert property (!((wr_set || wr_clr) && PWDATA_I[4:0] != '0)
        && mset == '0 && !MGR_EVT_I.tx_sent |=> $stable(READY_FLAGS_O))
        else $error("ready flags changed without cause");
    a_tx_len_write: assert property (wr && PADDR_I == OFF_TX_LEN
        |=> TX_LENGTH_O == $past(PWDATA_I[LEN_W-1:0]))
        else $error("transmit length not written");
    a_err_unmapped: assert property (PSEL_I && PENABLE_I |-> PSLVERR_O == !mapped)
        else $error("bus error does not match address map");
    a_err_idle: assert property (!(PSEL_I && PENABLE_I) |-> !PSLVERR_O)
        else $error("bus error outside access phase");
    c_set_locked: cover property (|set_no);
    c_clr_locked: cover property (|clr_no);
    c_tx_sent: cover property (MGR_EVT_I.tx_sent && READY_FLAGS_O[POS_TX]);
endmodule : hbuf_regs_checker
bind hbuf_regs hbuf_regs_checker u_chk (
    .REF_CLK_I(REF_CLK_I), .RST_N_I(RST_N_I), .CE_I(CE_I), .PSEL_I(PSEL_I),
    .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I),
    .PSLVERR_O(PSLVERR_O), .MGR_EVT_I(MGR_EVT_I), .READY_FLAGS_O(READY_FLAGS_O),
    .TX_LENGTH_O(TX_LENGTH_O)
);
`default_nettype wire

/* hbuf_tick.sv */
// Prescaler producing one pulse every timeout step
`timescale 1ns/1ps
`default_nettype none
module hbuf_tick (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    input wire logic run_i,
    output logic tick_o
);
    import hbuf_pkg::*;

    typedef struct packed {
        logic [7:0] cnt;
    } tick_state_s;

    tick_state_s state_ff;
    tick_state_s nxt_state;

    always_comb begin
        nxt_state = state_ff;
        if (!run_i) begin
            nxt_state.cnt = 8'h00;
        end else if (state_ff.cnt == STEP_CYCLES - 8'h01) begin
            nxt_state.cnt = 8'h00;
        end else begin
            nxt_state.cnt = state_ff.cnt + 8'h01;
        end
    end

    assign tick_o = run_i && (state_ff.cnt == STEP_CYCLES - 8'h01);

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_ff <= '0;
        end else if (ce_i) begin
            state_ff <= nxt_state;
        end
    end
endmodule : hbuf_tick
`default_nettype wire

/* hbuf_timeout.sv */
// Inter-character timeout counter, restarted by every received byte except a frame's last byte, which stops it
`timescale 1ns/1ps
`default_nettype none
module hbuf_timeout (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    input wire logic [hbuf_pkg::TMO_W-1:0] limit_i,
    input wire logic byte_i,
    input wire logic frame_end_i,
    output logic expire_o
);
    import hbuf_pkg::*;

    typedef struct packed {
        logic armed;
        logic [TMO_W-1:0] steps;
    } tmo_state_s;

    tmo_state_s state_ff;
    tmo_state_s nxt_state;
    logic tick;
    logic hit;

    hbuf_tick u_tick (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .ce_i(ce_i),
        .run_i(state_ff.armed && !byte_i),
        .tick_o(tick)
    );

    assign hit = tick && (state_ff.steps == limit_i - 16'h0001);
    assign expire_o = state_ff.armed && (limit_i != RST_TMO) && hit;

    always_comb begin
        nxt_state = state_ff;
        if (byte_i) begin
            nxt_state.armed = (limit_i != RST_TMO) && !frame_end_i;
            nxt_state.steps = '0;
        end else if (limit_i == RST_TMO || hit) begin
            nxt_state.armed = 1'b0;
            nxt_state.steps = '0;
        end else if (tick) begin
            nxt_state.steps = state_ff.steps + 16'h0001;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_ff <= '0;
        end else if (ce_i) begin
            state_ff <= nxt_state;
        end
    end
endmodule : hbuf_timeout
`default_nettype wire

/* test_host_buffer_length_and_ready_regs.sv */
// Self-checking bench of the buffer length and ready-flag register bank
`timescale 1ns/1ps
`default_nettype none
module test_host_buffer_length_and_ready_regs;
    import hbuf_pkg::*;
    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic [31:0] rdata;
    } row_s;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata, q;
    logic pready, pslverr, e, irq_a, irq, mode, tmo;
    logic [NBUF-1:0] flags;
    logic [LEN_W-1:0] txlen;
    rx_byte_s rx_byte;
    mgr_evt_s mgr_evt;
    int mismatches = 0;
    int total_checks = 0;
    row_s rows [7] = '{'{OFF_TX_LEN, 32'hFFFF_FFFF, 32'h0000_07FF},
        '{OFF_TX_LEN, 32'h0000_0555, 32'h0000_0555}, '{OFF_TIMEOUT, 32'hFFFF_FFFF, 32'h0000_FFFF},
        '{OFF_THRESH, 32'hFFFF_FFFF, 32'h0000_07FF}, '{OFF_SET, 32'h0000_0000, 32'h0000_0000},
        '{OFF_CLR, 32'h0000_0000, 32'h0000_0000}, '{8'h90, 32'hFFFF_FFFF, 32'h0000_0000}};

    initial forever #20 clk = ~clk;

    hbuf_regs u_dut (.REF_CLK_I(clk), .RST_N_I(rst_n), .CE_I(1'b1), .PSEL_I(psel),
        .PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata),
        .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr), .RX_BYTE_I(rx_byte),
        .MGR_EVT_I(mgr_evt), .READY_FLAGS_O(flags), .TX_LENGTH_O(txlen), .LENGTH_FIELD_MODE_O(mode),
        .RX_TIMEOUT_O(tmo), .IRQ_O(irq));
    hbuf_host_model u_host (.clk_i(clk), .rx_byte_o(rx_byte), .evt_o(mgr_evt));

    // ==================================================================
    // Tasks
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk
    // Entered just after a rising edge; leaves one idle edge behind it
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        // Waits as long as the slave stalls; only the watchdog ends a hang
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : apb
    task automatic complete_run;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : complete_run

    initial begin
        repeat (20000) @(posedge clk);
        mismatches++;
        complete_run();
    end

    // ==================================================================
    // Main sequence
    initial begin
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 9; i++) begin
            apb(1'b0, 8'h4c + 8'(4 * i), 32'h0);
            chk("reset value", q, 32'h0000_0000);
        end
        foreach (rows[i]) begin
            apb(1'b1, rows[i].addr, rows[i].wdata);
            apb(1'b0, rows[i].addr, 32'h0);
            chk("readback", q, rows[i].rdata);
        end
        chk("unmapped error", 32'(e), 32'h1);
        chk("tx length out", 32'(txlen), 32'h0000_0555);
        // Ready flags against locks and manager events
        apb(1'b1, OFF_SET, 32'h0000_001F);
        chk("set all", 32'(flags), 32'h1F);
        u_host.set_lock(5'h1F);
        apb(1'b1, OFF_CLR, 32'h0000_001F);
        chk("clear locked", 32'(flags), 32'h1F);
        u_host.set_lock(5'h00);
        apb(1'b1, OFF_CLR, 32'h0000_0015);
        chk("clear part", 32'(flags), 32'h0A);
        u_host.set_lock(5'h15);
        apb(1'b1, OFF_CLR, 32'h0000_000A);
        apb(1'b1, OFF_SET, 32'h0000_001F);
        apb(1'b0, OFF_READY, 32'h0);
        chk("set locked", q, 32'h0A);
        u_host.set_lock(5'h00);
        apb(1'b1, OFF_SET, 32'h0000_0010);
        u_host.mgr_pulse(4'h1, 1'b1);
        chk("manager events", 32'(flags), 32'h0B);
        // Frame lengths, check-code bits and threshold
        apb(1'b1, OFF_CTRL, 32'h0000_0001);
        chk("length mode", 32'(mode), 32'h1);
        apb(1'b1, OFF_THRESH, 32'h0000_0003);
        u_host.send_frame(2'd2, 5, 0, 1'b1, 1'b1, 1'b1);
        u_host.send_frame(2'd1, 4, 3, 1'b0, 1'b0, 1'b1);
        u_host.send_frame(2'd3, 2, 1, 1'b1, 1'b0, 1'b1);
        apb(1'b0, OFF_RX2_LEN, 32'h0);
        chk("rx2 length", q, 32'h0000_1805);
        apb(1'b0, OFF_RX1_LEN, 32'h0);
        chk("rx1 length", q, 32'h0000_0004);
        apb(1'b0, OFF_RX3_LEN, 32'h0);
        chk("rx3 length", q, 32'h0000_0802);
        apb(1'b0, OFF_IRQ_STAT, 32'h0);
        chk("threshold event", q & 32'h2, 32'h2);
        apb(1'b1, OFF_IRQ_MASK, 32'h0000_0007);
        irq_a = irq;
        apb(1'b1, OFF_IRQ_MASK, 32'h0000_0000);
        chk("irq mask effect", 32'(irq_a ^ irq), 32'h1);
        apb(1'b1, OFF_IRQ_STAT, 32'h0000_0007);
        chk("irq cleared", 32'(irq), 32'h0);
        apb(1'b0, OFF_IRQ_STAT, 32'h0);
        chk("irq status cleared", q, 32'h0000_0000);
        apb(1'b1, OFF_THRESH, 32'h0000_0000);
        u_host.send_frame(2'd0, 5, 0, 1'b0, 1'b0, 1'b1);
        apb(1'b0, OFF_IRQ_STAT, 32'h0);
        chk("threshold off", q & 32'h2, 32'h0);
        // Inter-character timeout: off, restart, expiry after 4 steps
        apb(1'b1, OFF_TIMEOUT, 32'h0000_0000);
        u_host.send_frame(2'd0, 1, 300, 1'b0, 1'b0, 1'b0);
        chk("timeout off", 32'(tmo), 32'h0);
        apb(1'b1, OFF_TIMEOUT, 32'h0000_0004);
        u_host.send_frame(2'd0, 1, 200, 1'b0, 1'b0, 1'b0);
        chk("timeout early", 32'(tmo), 32'h0);
        u_host.send_frame(2'd0, 1, 200, 1'b0, 1'b0, 1'b0);
        chk("timeout restart", 32'(tmo), 32'h0);
        repeat (250) @(posedge clk);
        chk("timeout fired", 32'(tmo), 32'h1);
        // Mid-run reset: flags and sticky timeout must drop
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        chk("reset flags", 32'(flags), 32'h0);
        chk("reset timeout", 32'(tmo), 32'h0);
        apb(1'b0, OFF_TX_LEN, 32'h0);
        chk("reset tx length", q, 32'h0000_0000);
        complete_run();
    end
endmodule : test_host_buffer_length_and_ready_regs
`default_nettype wire
